// >>> design/cmp_ctrl_pkg.sv
// Package: register map, field layout and carriers for the comparator control block
package cmp_ctrl_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG_A      = 8'h00;
	localparam logic [7:0] OFF_CONFIG_B      = 8'h04;
	localparam logic [7:0] OFF_WINDOW_CONFIG = 8'h08;
	localparam logic [7:0] OFF_EV0_SOURCE    = 8'h0C;
	localparam logic [7:0] OFF_EV1_SOURCE    = 8'h10;
	localparam logic [7:0] OFF_ENABLE        = 8'h1C;
	localparam logic [7:0] OFF_DISABLE       = 8'h20;
	localparam logic [7:0] OFF_STARTUP       = 8'h24;
	localparam logic [7:0] OFF_IRQ_ENABLE    = 8'h28;
	localparam logic [7:0] OFF_IRQ_DISABLE   = 8'h2C;
	localparam logic [7:0] OFF_IRQ_MASK      = 8'h30;
	localparam logic [7:0] OFF_EVENT_ENABLE  = 8'h34;
	localparam logic [7:0] OFF_EVENT_DISABLE = 8'h38;
	localparam logic [7:0] OFF_EVENT_MASK    = 8'h3C;
	localparam logic [7:0] OFF_STATUS        = 8'h40;
	localparam logic [7:0] OFF_FLAG_CLEAR    = 8'h44;

	// Enable and disable strobe bit positions
	localparam int unsigned BIT_CMP_A  = 0;
	localparam int unsigned BIT_CMP_B  = 1;
	localparam int unsigned BIT_WINDOW = 2;
	localparam int unsigned BIT_CPR_A  = 3;
	localparam int unsigned BIT_CPR_B  = 4;

	// Interrupt bit positions
	localparam int unsigned IRQ_CMP_A  = 0;
	localparam int unsigned IRQ_CMP_B  = 1;
	localparam int unsigned IRQ_WINDOW = 2;
	localparam int unsigned IRQ_SUT_A  = 3;
	localparam int unsigned IRQ_SUT_B  = 4;
	localparam int unsigned IRQ_N      = 5;

	// Status field positions
	localparam int unsigned ST_ENABLE_LSB  = 8;
	localparam int unsigned ST_CURRENT_LSB = 16;
	localparam int unsigned ST_READY_LSB   = 24;

	localparam int unsigned SUT_W     = 10;
	localparam int unsigned EVSRC_W   = 4;
	localparam int unsigned TRIG_W    = 2;
	localparam int unsigned TRIG_LSB  = 0;
	localparam int unsigned EVSRC_LSB = 0;

	localparam logic [DATA_W-1:0] RST_CONFIG  = 32'h8000_0000;
	localparam logic [DATA_W-1:0] RST_ZERO    = 32'h0000_0000;
	localparam logic [SUT_W-1:0]  RST_SUT     = 10'h000;
	localparam logic [IRQ_N-1:0]  RST_MASK    = 5'h00;

	typedef enum logic [TRIG_W-1:0] {
		TRIG_ABOVE  = 2'h0,
		TRIG_BELOW  = 2'h1,
		TRIG_TOGGLE = 2'h2,
		TRIG_NONE   = 2'h3
	} trig_mode_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_type;

	typedef struct packed {
		logic comparator_b_on;
		logic comparator_a_on;
	} analog_ctrl_type;

endpackage : cmp_ctrl_pkg

// >>> design/cmp_startup_timer.sv
// Startup delay counter for one analog comparator
`timescale 1ns/10ps
`default_nettype none

module cmp_startup_timer (
	// Clock and reset
	input  wire logic                            i_core_clk,
	input  wire logic                            i_rst_n,
	// Control
	input  wire logic                            i_comparator_on,
	input  wire logic [cmp_ctrl_pkg::SUT_W-1:0]  i_startup_delay_count,
	// Result
	output logic                                 o_ready,
	output logic                                 o_ready_rise
);

	logic [cmp_ctrl_pkg::SUT_W-1:0] count_r;
	logic                           ready_r;
	logic                           ready_nxt;

	// Count restarts from zero each time the comparator goes off
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_r <= cmp_ctrl_pkg::RST_SUT;
		end else if (!i_comparator_on) begin
			count_r <= cmp_ctrl_pkg::RST_SUT;
		end else if (!ready_nxt) begin
			count_r <= count_r + 10'h001;
		end
	end

	// Ready once count periods have passed since enable
	assign ready_nxt = i_comparator_on && (count_r >= i_startup_delay_count);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ready_r <= 1'b0;
		end else begin
			ready_r <= ready_nxt;
		end
	end

	assign o_ready      = ready_r;
	assign o_ready_rise = ready_nxt && !ready_r;

endmodule : cmp_startup_timer
`default_nettype wire

// >>> design/comparator_enable_irq_control.sv
// Comparator enable, startup, interrupt and event control register bank
// Contract
// - Comparison enable bits start A/B comparison
// - Window enable forces comparators and comparisons on
// - Comparator enable bits switch comparator on
// - Zero written to strobes changes nothing
// - Disable strobe at 0x20; comparison-off stops
// - Window off clears both comparison enables
// - Comparator disable bits switch comparator off
// - Startup count bits 9:0 times clock period
// - Comparison valid only after startup delay
// - Interrupt enable strobe at 0x28 sets mask
// - Interrupt disable strobe at 0x2C clears mask
// - Mask view at 0x30 tracks strobes
// - Mask resets to zero, all disabled
// - Window irq gated by window trigger mode
// - Comparator irq gated by own trigger mode
// - Event enable strobe at 0x34 enables events
// - Flag clear strobe clears flag and request
// - Startup flag pends when the comparator startup delay ends
// - Trigger 00 above, 01 below, 10 toggle
// - Event disable strobe turns event off
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module comparator_enable_irq_control (
	// Clock and reset
	input  wire logic                               i_core_clk,
	input  wire logic                               i_rst_n,
	// Register port
	input  wire logic [cmp_ctrl_pkg::ADDR_W-1:0]    i_addr,
	input  wire logic [cmp_ctrl_pkg::DATA_W-1:0]    i_wdata,
	input  wire logic                               i_wr,
	input  wire logic                               i_rd,
	output logic      [cmp_ctrl_pkg::DATA_W-1:0]    o_rdata,
	// Analog side
	input  wire logic                               i_comparator_a_out,
	input  wire logic                               i_comparator_b_out,
	input  wire logic                               i_window_out,
	output cmp_ctrl_pkg::analog_ctrl_type           o_analog_ctrl,
	// Events and interrupt
	output logic      [1:0]                         o_event,
	output logic                                    o_irq
);

	cmp_ctrl_pkg::bus_req_type req;
	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	logic [cmp_ctrl_pkg::DATA_W-1:0]  config_a_r;
	logic [cmp_ctrl_pkg::DATA_W-1:0]  config_b_r;
	logic [cmp_ctrl_pkg::DATA_W-1:0]  window_config_r;
	logic [cmp_ctrl_pkg::EVSRC_W-1:0] ev_src_r [2];
	logic [cmp_ctrl_pkg::SUT_W-1:0]   startup_delay_count_r;
	logic [4:0]                       on_r;
	logic [cmp_ctrl_pkg::IRQ_N-1:0]   mask_r;
	logic [cmp_ctrl_pkg::IRQ_N-1:0]   flag_r;
	logic [1:0]                       event_gate_r;
	logic [2:0]                       out_prev_r;
	logic [1:0]                       event_r;
	logic [cmp_ctrl_pkg::DATA_W-1:0]  rdata_r;

	logic wr_en;
	logic wr_dis;
	logic ready_a;
	logic ready_b;
	logic ready_a_rise;
	logic ready_b_rise;
	assign wr_en  = req.wr && (req.addr == cmp_ctrl_pkg::OFF_ENABLE);
	assign wr_dis = req.wr && (req.addr == cmp_ctrl_pkg::OFF_DISABLE);

	// Configuration registers
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			config_a_r            <= cmp_ctrl_pkg::RST_CONFIG;
			config_b_r            <= cmp_ctrl_pkg::RST_CONFIG;
			window_config_r       <= cmp_ctrl_pkg::RST_ZERO;
			ev_src_r[0]           <= 4'h0;
			ev_src_r[1]           <= 4'h0;
			startup_delay_count_r <= cmp_ctrl_pkg::RST_SUT;
		end else if (req.wr) begin
			unique case (req.addr)
				cmp_ctrl_pkg::OFF_CONFIG_A:      config_a_r <= req.wdata;
				cmp_ctrl_pkg::OFF_CONFIG_B:      config_b_r <= req.wdata;
				cmp_ctrl_pkg::OFF_WINDOW_CONFIG: window_config_r <= req.wdata;
				cmp_ctrl_pkg::OFF_EV0_SOURCE:    ev_src_r[0] <= req.wdata[3:0];
				cmp_ctrl_pkg::OFF_EV1_SOURCE:    ev_src_r[1] <= req.wdata[3:0];
				cmp_ctrl_pkg::OFF_STARTUP:       startup_delay_count_r <= req.wdata[9:0];
				default: ;
			endcase
		end
	end

	// Enable state: on_r bits follow the strobe layout
	logic [4:0] on_nxt;
	always_comb begin
		on_nxt = on_r;
		if (wr_en) begin
			on_nxt = on_r | req.wdata[4:0];
			if (req.wdata[cmp_ctrl_pkg::BIT_WINDOW]) begin
				on_nxt = 5'h1F;
			end
		end else if (wr_dis) begin
			on_nxt = on_r & ~req.wdata[4:0];
			if (req.wdata[cmp_ctrl_pkg::BIT_WINDOW]) begin
				on_nxt[cmp_ctrl_pkg::BIT_CPR_A] = 1'b0;
				on_nxt[cmp_ctrl_pkg::BIT_CPR_B] = 1'b0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			on_r <= 5'h00;
		end else begin
			on_r <= on_nxt;
		end
	end

	assign o_analog_ctrl = '{comparator_b_on: on_r[cmp_ctrl_pkg::BIT_CMP_B],
		comparator_a_on: on_r[cmp_ctrl_pkg::BIT_CMP_A]};

	// Startup delay per comparator
	cmp_startup_timer u_sut_a (
		.i_core_clk            (i_core_clk),
		.i_rst_n               (i_rst_n),
		.i_comparator_on       (on_r[cmp_ctrl_pkg::BIT_CMP_A]),
		.i_startup_delay_count (startup_delay_count_r),
		.o_ready               (ready_a),
		.o_ready_rise          (ready_a_rise)
	);
	cmp_startup_timer u_sut_b (
		.i_core_clk            (i_core_clk),
		.i_rst_n               (i_rst_n),
		.i_comparator_on       (on_r[cmp_ctrl_pkg::BIT_CMP_B]),
		.i_startup_delay_count (startup_delay_count_r),
		.o_ready               (ready_b),
		.o_ready_rise          (ready_b_rise)
	);

	// Valid comparison needs comparator ready and comparison on
	logic valid_a;
	logic valid_b;
	logic valid_w;
	assign valid_a = ready_a && on_r[cmp_ctrl_pkg::BIT_CPR_A];
	assign valid_b = ready_b && on_r[cmp_ctrl_pkg::BIT_CPR_B];
	assign valid_w = valid_a && valid_b && on_r[cmp_ctrl_pkg::BIT_WINDOW];

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_prev_r <= 3'h0;
		end else begin
			out_prev_r <= {i_window_out, i_comparator_b_out, i_comparator_a_out};
		end
	end

	// Above and below are level modes, so the flag sets again every cycle the condition holds
	function automatic logic trig_hit(input logic [1:0] mode, input logic now, input logic prev);
		unique case (cmp_ctrl_pkg::trig_mode_type'(mode))
			cmp_ctrl_pkg::TRIG_ABOVE:  trig_hit = now;
			cmp_ctrl_pkg::TRIG_BELOW:  trig_hit = !now;
			cmp_ctrl_pkg::TRIG_TOGGLE: trig_hit = now ^ prev;
			default:                   trig_hit = 1'b0;
		endcase
	endfunction : trig_hit

	logic [cmp_ctrl_pkg::IRQ_N-1:0] flag_set;
	logic [cmp_ctrl_pkg::IRQ_N-1:0] flag_clr;
	assign flag_set[cmp_ctrl_pkg::IRQ_CMP_A] = valid_a &&
		trig_hit(config_a_r[1:0], i_comparator_a_out, out_prev_r[0]);
	assign flag_set[cmp_ctrl_pkg::IRQ_CMP_B] = valid_b &&
		trig_hit(config_b_r[1:0], i_comparator_b_out, out_prev_r[1]);
	assign flag_set[cmp_ctrl_pkg::IRQ_WINDOW] = valid_w &&
		trig_hit(window_config_r[1:0], i_window_out, out_prev_r[2]);
	assign flag_set[cmp_ctrl_pkg::IRQ_SUT_A] = ready_a_rise;
	assign flag_set[cmp_ctrl_pkg::IRQ_SUT_B] = ready_b_rise;
	assign flag_clr = (req.wr && req.addr == cmp_ctrl_pkg::OFF_FLAG_CLEAR) ? req.wdata[4:0] : 5'h00;

	// Set wins over a clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_r <= 5'h00;
		end else begin
			flag_r <= (flag_r & ~flag_clr) | flag_set;
		end
	end

	// Interrupt mask
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_r <= cmp_ctrl_pkg::RST_MASK;
		end else if (req.wr && req.addr == cmp_ctrl_pkg::OFF_IRQ_ENABLE) begin
			mask_r <= mask_r | req.wdata[4:0];
		end else if (req.wr && req.addr == cmp_ctrl_pkg::OFF_IRQ_DISABLE) begin
			mask_r <= mask_r & ~req.wdata[4:0];
		end
	end

	assign o_irq = |(flag_r & mask_r);

	// Event gates
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			event_gate_r <= 2'h0;
		end else if (req.wr && req.addr == cmp_ctrl_pkg::OFF_EVENT_ENABLE) begin
			event_gate_r <= event_gate_r | req.wdata[1:0];
		end else if (req.wr && req.addr == cmp_ctrl_pkg::OFF_EVENT_DISABLE) begin
			event_gate_r <= event_gate_r & ~req.wdata[1:0];
		end
	end

	// Source codes above eight select nothing and never fire
	function automatic logic ev_hit(input logic [3:0] src, input logic [2:0] now, input logic [2:0] prev);
		logic rise;
		logic fall;
		rise = 1'b0;
		fall = 1'b0;
		if (src <= 4'h8) begin
			rise = now[src / 3] && !prev[src / 3];
			fall = !now[src / 3] && prev[src / 3];
		end
		unique case (src % 3)
			4'h0:    ev_hit = rise;
			4'h1:    ev_hit = fall;
			default: ev_hit = rise || fall;
		endcase
	endfunction : ev_hit

	logic [2:0] out_now;
	logic [2:0] out_valid;
	assign out_now   = {i_window_out, i_comparator_b_out, i_comparator_a_out};
	assign out_valid = {valid_w, valid_b, valid_a};

	// Events only from outputs whose comparison is valid
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			event_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				event_r[i] <= event_gate_r[i] &&
					ev_hit(ev_src_r[i], out_now & out_valid, out_prev_r & out_valid);
			end
		end
	end
	assign o_event = event_r;

	// Read port; write-only and unmapped offsets read zero
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= cmp_ctrl_pkg::RST_ZERO;
		end else if (req.rd) begin
			rdata_r <= cmp_ctrl_pkg::RST_ZERO;
			unique case (req.addr)
				cmp_ctrl_pkg::OFF_CONFIG_A:      rdata_r <= config_a_r;
				cmp_ctrl_pkg::OFF_CONFIG_B:      rdata_r <= config_b_r;
				cmp_ctrl_pkg::OFF_WINDOW_CONFIG: rdata_r <= window_config_r;
				cmp_ctrl_pkg::OFF_EV0_SOURCE:    rdata_r[3:0] <= ev_src_r[0];
				cmp_ctrl_pkg::OFF_EV1_SOURCE:    rdata_r[3:0] <= ev_src_r[1];
				cmp_ctrl_pkg::OFF_STARTUP:       rdata_r[9:0] <= startup_delay_count_r;
				cmp_ctrl_pkg::OFF_IRQ_MASK:      rdata_r[4:0] <= mask_r;
				cmp_ctrl_pkg::OFF_EVENT_MASK:    rdata_r[1:0] <= event_gate_r;
				cmp_ctrl_pkg::OFF_STATUS:        rdata_r <= {5'h00, valid_w, valid_b, valid_a,
					5'h00, out_now, 3'h0, on_r, 3'h0, flag_r};
				default: ;
			endcase
		end else begin
			rdata_r <= cmp_ctrl_pkg::RST_ZERO;
		end
	end
	assign o_rdata = rdata_r;

	// Checks
	a_window_forces_on: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_en && req.wdata[2] |=> on_r == 5'h1F)
		else $error("window enable did not force all on");
	a_window_off_cpr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_dis && req.wdata[2] |=> on_r[4:3] == 2'b00 && on_r[1:0] == ($past(on_r[1:0]) & ~$past(req.wdata[1:0])))
		else $error("window disable wrong");
	a_zero_write_keeps: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(wr_en || wr_dis) && req.wdata[4:0] == 5'h00 |=> $stable(on_r))
		else $error("zero write changed state");
	a_cmp_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_dis && req.wdata[0] |=> !o_analog_ctrl.comparator_a_on)
		else $error("comparator A not off");
	a_mask_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		req.wr && req.addr == 8'h28 |=> (mask_r & $past(req.wdata[4:0])) == $past(req.wdata[4:0]))
		else $error("mask bit not set");
	a_mask_disable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		req.wr && req.addr == 8'h2C |=> (mask_r & $past(req.wdata[4:0])) == 5'h00)
		else $error("mask bit not cleared");
	a_irq_output: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(mask_r == 5'h00) || (flag_r == 5'h00) |-> !o_irq)
		else $error("irq without masked-in flag");
	a_no_early_valid: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(on_r[0]) && startup_delay_count_r == 10'h005 |-> (!ready_a) [*6])
		else $error("ready too early");
	a_sut_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		ready_a_rise |=> flag_r[3])
		else $error("startup flag missed");
	a_event_gate: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		req.wr && req.addr == 8'h38 && req.wdata[0] |=> ##1 !o_event[0])
		else $error("event not gated");
	a_cpr_on: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_en && req.wdata[4:3] != 2'b00 |=> (on_r[4:3] & $past(req.wdata[4:3])) == $past(req.wdata[4:3]))
		else $error("comparison enable not taken");
	a_cmp_on: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_en && req.wdata[1] |=> o_analog_ctrl.comparator_b_on)
		else $error("comparator B not on");
	a_cpr_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		wr_dis && req.wdata[4:3] != 2'b00 |=> (on_r[4:3] & $past(req.wdata[4:3])) == 2'b00)
		else $error("comparison not stopped");
	a_sut_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		req.wr && req.addr == 8'h24 |=> startup_delay_count_r == $past(req.wdata[9:0]))
		else $error("startup count not stored");
	a_off_not_valid: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!on_r[0] |=> !valid_a)
		else $error("comparison valid while comparator off");
	a_mask_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		req.rd && req.addr == 8'h30 |=> o_rdata == {27'h0, $past(mask_r)})
		else $error("mask view wrong");
	a_mask_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> mask_r == 5'h00)
		else $error("mask not zero after reset");
	a_window_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		valid_w && window_config_r[1:0] == 2'h0 && i_window_out |=> flag_r[2])
		else $error("window irq missed");
	a_below_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		valid_a && config_a_r[1:0] == 2'h1 && !i_comparator_a_out |=> flag_r[0])
		else $error("comparator A below irq missed");
	a_toggle_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		valid_b && config_b_r[1:0] == 2'h2 && (i_comparator_b_out != out_prev_r[1]) |=> flag_r[1])
		else $error("comparator B toggle irq missed");
	a_flag_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		flag_clr != 5'h00 |=> (flag_r & $past(flag_clr) & ~$past(flag_set)) == 5'h00)
		else $error("flag not cleared");
	a_event_enable: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		req.wr && req.addr == 8'h34 |=> (event_gate_r & $past(req.wdata[1:0])) == $past(req.wdata[1:0]))
		else $error("event gate not set");

	c_window_on: cover property (@(posedge i_core_clk) wr_en && req.wdata[2]);
	c_flag_clear: cover property (@(posedge i_core_clk) flag_clr != 5'h00);
	c_irq_fire: cover property (@(posedge i_core_clk) $rose(o_irq));
	c_startup_done: cover property (@(posedge i_core_clk) ready_a_rise);
	c_event_out: cover property (@(posedge i_core_clk) o_event != 2'h0);

endmodule : comparator_enable_irq_control
`default_nettype wire

// >>> tb/analog_pair_model.sv
// Behavioural model of the two analog comparators and their window stage
`timescale 1ns/10ps
`default_nettype none

module analog_pair_model (
	// Clock
	input  wire logic                          i_core_clk,
	// Power control from the block and levels chosen by the bench
	input  wire cmp_ctrl_pkg::analog_ctrl_type i_ctrl,
	input  wire logic [2:0]                    i_level,
	// Comparator and window outputs
	output logic                               o_a_out,
	output logic                               o_b_out,
	output logic                               o_win_out
);
	logic junk_r = 1'b0;

	// An unpowered comparator has no defined answer, so it shows a pattern that flips every cycle
	always @(posedge i_core_clk) begin
		junk_r <= ~junk_r;
	end

	assign o_a_out   = i_ctrl.comparator_a_on ? i_level[0] : junk_r;
	assign o_b_out   = i_ctrl.comparator_b_on ? i_level[1] : ~junk_r;
	// The window stage needs both comparators powered
	assign o_win_out = (i_ctrl.comparator_a_on && i_ctrl.comparator_b_on) ? i_level[2] : junk_r;
endmodule : analog_pair_model

`default_nettype wire

// >>> tb/comparator_enable_irq_control_bench.sv
// Self-checking bench for the comparator enable and interrupt control block
`timescale 1ns/10ps
`default_nettype none

module comparator_enable_irq_control_bench;
	logic                          i_core_clk  = 1'b0;
	logic                          i_rst_n     = 1'b0;
	logic [7:0]                    i_addr      = 8'h00;
	logic [31:0]                   i_wdata     = 32'h0000_0000;
	logic                          i_wr        = 1'b0;
	logic                          i_rd        = 1'b0;
	logic [2:0]                    level       = 3'h0;
	logic [31:0]                   o_rdata;
	logic                          cmp_a;
	logic                          cmp_b;
	logic                          win;
	cmp_ctrl_pkg::analog_ctrl_type analog_ctrl;
	logic [1:0]                    o_event;
	logic                          o_irq;
	int                            ev_cnt      = 0;
	int                            ev1_cnt     = 0;
	int                            n_errors    = 0;
	int                            checks_done = 0;
	// Write offset, write data, readback offset, expected field (mask bits, or enable state of the status)
	logic [31:0]                   tab [18]    = '{32'h281F301F, 32'h2C05301A, 32'h2800301A, 32'h2C00301A,
		32'h2C1F3000, 32'h28143014, 32'h2C143000, 32'h1C04401F, 32'h20044003, 32'h20004003, 32'h1C08400B,
		32'h1C10401B, 32'h2010400B, 32'h20084003, 32'h20024001, 32'h1C004001, 32'h1C024003, 32'h20034000};

	always #10 i_core_clk = ~i_core_clk;

	always @(posedge i_core_clk) begin
		if (o_event[0] === 1'b1) begin
			ev_cnt <= ev_cnt + 1;
		end
		if (o_event[1] === 1'b1) begin
			ev1_cnt <= ev1_cnt + 1;
		end
	end

	comparator_enable_irq_control i_dut (
		.i_core_clk         (i_core_clk),
		.i_rst_n            (i_rst_n),
		.i_addr             (i_addr),
		.i_wdata            (i_wdata),
		.i_wr               (i_wr),
		.i_rd               (i_rd),
		.o_rdata            (o_rdata),
		.i_comparator_a_out (cmp_a),
		.i_comparator_b_out (cmp_b),
		.i_window_out       (win),
		.o_analog_ctrl      (analog_ctrl),
		.o_event            (o_event),
		.o_irq              (o_irq)
	);

	analog_pair_model i_model (
		.i_core_clk (i_core_clk),
		.i_ctrl     (analog_ctrl),
		.i_level    (level),
		.o_a_out    (cmp_a),
		.o_b_out    (cmp_b),
		.o_win_out  (win)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata & m, e);
	endtask : rchk

	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : cyc

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	initial begin
		int          n;
		logic [31:0] startup_delay_count;
		logic        q;
		logic [23:0] e;
		repeat (12) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rchk(8'h30, 32'hFFFF_FFFF, 32'h0);
		rchk(8'h00, 32'hFFFF_FFFF, 32'h8000_0000);
		rchk(8'h24, 32'hFFFF_FFFF, 32'h0);
		rchk(8'h20, 32'hFFFF_FFFF, 32'h0);
		rchk(8'h50, 32'hFFFF_FFFF, 32'h0);
		chk({29'h0, analog_ctrl, o_irq}, 32'h0);
		$display("test reset done");
		wr(8'h28, 32'h0000_0008);
		for (int k = 0; k < 2; k++) begin
			startup_delay_count = 32'(k * 5);
			wr(8'h24, startup_delay_count);
			rchk(8'h24, 32'hFFFF_FFFF, startup_delay_count);
			wr(8'h1C, 32'h0000_0009);
			n = 0;
			do begin
				@(posedge i_core_clk);
				#1;
				n++;
			end while (o_irq !== 1'b1 && n < 40);
			chk(32'(n), startup_delay_count + 32'd1);
			chk({30'h0, analog_ctrl}, 32'h1);
			rchk(8'h40, 32'h0100_0008, 32'h0100_0008);
			wr(8'h44, 32'h0000_0008);
			#1;
			chk({31'h0, o_irq}, 32'h0);
			wr(8'h20, 32'h0000_0009);
			#1;
			chk({30'h0, analog_ctrl}, 32'h0);
		end
		$display("test startup done");
		for (int i = 0; i < 18; i++) begin
			wr(tab[i][31:24], {24'h0, tab[i][23:16]});
			if (tab[i][15:8] == 8'h40) begin
				rchk(8'h40, 32'h0000_1F00, {16'h0, tab[i][7:0], 8'h00});
				chk({30'h0, analog_ctrl}, {30'h0, tab[i][1:0]});
			end else begin
				rchk(8'h30, 32'h0000_00FF, {24'h0, tab[i][7:0]});
			end
		end
		$display("test strobes done");
		wr(8'h24, 32'h0000_0002);
		wr(8'h1C, 32'h0000_0004);
		wr(8'h2C, 32'h0000_001F);
		cyc(8);
		for (int idx = 0; idx < 3; idx++) begin
			wr(8'h28, 32'h1 << idx);
			for (int m = 0; m < 4; m++) begin
				q = (m == 0) ? 1'b0 : (m == 1) ? 1'b1 : level[idx];
				wr(8'(idx * 4), 32'(m));
				level[idx] <= q;
				cyc(3);
				wr(8'h44, 32'h1 << idx);
				rchk(8'h40, 32'h1 << idx, 32'h0);
				chk({31'h0, o_irq}, 32'h0);
				level[idx] <= ~q;
				cyc(3);
				rchk(8'h40, 32'h1 << idx, (m == 3) ? 32'h0 : (32'h1 << idx));
				chk({31'h0, o_irq}, (m == 3) ? 32'h0 : 32'h1);
			end
			wr(8'h2C, 32'h1 << idx);
		end
		$display("test trigger modes done");
		wr(8'h0C, 32'h0);
		level[0] <= 1'b0;
		cyc(3);
		for (int k = 0; k < 3; k++) begin
			e = (k == 0) ? 24'h340000 : (k == 1) ? 24'h340101 : 24'h380100;
			wr(e[23:16], {24'h0, e[15:8]});
			rchk(8'h3C, 32'h3, {24'h0, e[7:0]});
			n = ev_cnt;
			level[0] <= 1'b1;
			cyc(4);
			chk(32'(ev_cnt - n), {24'h0, e[7:0]});
			level[0] <= 1'b0;
			cyc(3);
		end
		wr(8'h34, 32'h0000_0002);
		level[0] <= 1'b1;
		cyc(4);
		chk(32'(ev1_cnt), 32'h1);
		$display("test events done");
		final_report();
	end

	// Whole run needs under four hundred cycles; this allows ten thousand
	initial begin
		#200000;
		n_errors++;
		final_report();
	end
endmodule : comparator_enable_irq_control_bench

`default_nettype wire
